// ---- lsmcfg_regs.vh ----
`ifndef LSMCFG_REGS_VH
`define LSMCFG_REGS_VH

// register offsets
`define LSM_ADDR_THR_1_4   8'h04
`define LSM_ADDR_THR_5_8   8'h05
`define LSM_ADDR_THR_9_12  8'h06
`define LSM_ADDR_WDOG_CID  8'h07
`define LSM_ADDR_WD_PATT   8'h08
`define LSM_ADDR_OVRD      8'h09
`define LSM_ADDR_GRPA      8'h0A

// reset values
`define LSM_RST_THR        12'h000
`define LSM_RST_WD_DUR     4'h0
`define LSM_RST_CID        6'h01
`define LSM_RST_SW12       12'h000

// field positions
`define LSM_THR_MSB        11
`define LSM_WD_DUR_MSB     9
`define LSM_WD_DUR_LSB     6
`define LSM_CID_MSB        5
`define LSM_SW_MSB         11
`define LSM_GRPA_CODE      4'h1

// timing: watchdog runs on a 1 us tick
`define LSM_CLK_MHZ        200
`define LSM_TICK_NS        1000
`define LSM_TICK_CYCLES    ((`LSM_TICK_NS * `LSM_CLK_MHZ) / 1000)
`define LSM_WD_200US       23'h0000C8
`define LSM_WD_500US       23'h0001F4
`define LSM_WD_1MS         23'h0003E8
`define LSM_WD_2MS         23'h0007D0
`define LSM_WD_5MS         23'h001388
`define LSM_WD_10MS        23'h002710
`define LSM_WD_20MS        23'h004E20
`define LSM_WD_50MS        23'h00C350
`define LSM_WD_100MS       23'h0186A0
`define LSM_WD_200MS       23'h030D40
`define LSM_WD_500MS       23'h07A120
`define LSM_WD_1S          23'h0F4240
`define LSM_WD_2S          23'h1E8480
`define LSM_WD_5S          23'h4C4B40
`endif

// ---- lsmcfg_wdog.v ----
`timescale 1ns/1ps
`include "lsmcfg_regs.vh"
module lsmcfg_wdog #(
  parameter TICK_CYCLES = `LSM_TICK_CYCLES
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        srst_i,
  // control
  input  wire [3:0]  dur_code_i,
  input  wire        kick_i,
  // status
  output reg         timeout_o
);
  // ==========================================================
  // duration lookup, in microsecond ticks
  function [22:0] lsm_dur;
    input [3:0] code;
    begin
      case (code)
        4'h1:    lsm_dur = `LSM_WD_200US;
        4'h2:    lsm_dur = `LSM_WD_500US;
        4'h3:    lsm_dur = `LSM_WD_1MS;
        4'h4:    lsm_dur = `LSM_WD_2MS;
        4'h5:    lsm_dur = `LSM_WD_5MS;
        4'h6:    lsm_dur = `LSM_WD_10MS;
        4'h7:    lsm_dur = `LSM_WD_20MS;
        4'h8:    lsm_dur = `LSM_WD_50MS;
        4'h9:    lsm_dur = `LSM_WD_100MS;
        4'hA:    lsm_dur = `LSM_WD_200MS;
        4'hB:    lsm_dur = `LSM_WD_500MS;
        4'hC:    lsm_dur = `LSM_WD_1S;
        4'hD:    lsm_dur = `LSM_WD_2S;
        default: lsm_dur = `LSM_WD_5S;
      endcase
    end
  endfunction

  // divider end count, cut to the divider width on purpose
  localparam integer TICK_LAST_I = TICK_CYCLES - 1;
  localparam [15:0]  TICK_LAST   = TICK_LAST_I[15:0];

  reg  [15:0] div_cnt;
  reg  [22:0] us_cnt;
  reg  [3:0]  code_q;
  reg         expired;
  wire        tick    = (div_cnt == TICK_LAST);
  wire        enabled = (dur_code_i != `LSM_RST_WD_DUR);
  // a new code restarts the wait so a shorter setting cannot fire at once
  wire        restart = kick_i | (dur_code_i != code_q) | ~enabled;

  // ==========================================================
  // tick divider and silence counter
  always @(posedge clk_i) begin
    if (srst_i) begin
      div_cnt   <= 16'h0000;
      us_cnt    <= 23'h000000;
      code_q    <= `LSM_RST_WD_DUR;
      expired   <= 1'b0;
      timeout_o <= 1'b0;
    end else begin
      code_q    <= dur_code_i;
      timeout_o <= 1'b0;
      if (restart) begin
        div_cnt <= 16'h0000;
        us_cnt  <= 23'h000000;
        expired <= 1'b0;
      end else begin
        div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
        if (tick && !expired) begin
          if (us_cnt == lsm_dur(dur_code_i) - 23'h000001) begin
            timeout_o <= 1'b1;
            expired   <= 1'b1;
          end else begin
            us_cnt <= us_cnt + 23'h000001;
          end
        end
      end
    end
  end
endmodule // lsmcfg_wdog

// ---- lsmcfg_regs.v ----
`timescale 1ns/1ps
`include "lsmcfg_regs.vh"
module lsmcfg_regs #(
  parameter TICK_CYCLES = `LSM_TICK_CYCLES
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        srst_i,
  // register port from the serial command decoder
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  output reg  [15:0] reg_rdata_o,
  output reg         reg_rvalid_o,
  // serial link events
  input  wire        valid_cmd_i,
  input  wire [5:0]  cluster_id_rx_i,
  output wire        cluster_accept_o,
  input  wire        wd_flag_clr_i,
  output reg         wd_flag_o,
  output wire        fault_n_o,
  // dimming core
  input  wire        switching_enable_i,
  input  wire [11:0] pwm_open_i,
  output reg  [11:0] switch_open_o,
  output wire        pwm_counter_clear_o,
  output wire [11:0] fault_detect_en_o,
  output wire [35:0] short_threshold_select_o,
  // group A addressing
  input  wire        group_a_duty_wr_i,
  input  wire        group_phase_shift_wr_i,
  input  wire        group_dim_delay_wr_i,
  input  wire [3:0]  group_sel_code_i,
  output wire [11:0] group_a_duty_hit_o,
  output wire [11:0] group_a_phase_hit_o,
  output wire [11:0] group_a_delay_hit_o
);
  // ==========================================================
  // storage
  reg  [11:0] thr_1_4;
  reg  [11:0] thr_5_8;
  reg  [11:0] thr_9_12;
  reg  [3:0]  wd_dur;
  reg  [5:0]  cluster_id;
  reg  [11:0] wd_pattern;
  reg  [11:0] forced_closed;
  reg  [11:0] group_a_member;
  reg  [11:0] next_switch_open;
  wire        wd_timeout;

  // thresholds locked while switching runs, else the change is dropped
  wire thr_wr_ok = reg_wr_i & ~switching_enable_i;

  // ==========================================================
  // register writes
  always @(posedge clk_i) begin
    if (srst_i) begin
      thr_1_4        <= `LSM_RST_THR;
      thr_5_8        <= `LSM_RST_THR;
      thr_9_12       <= `LSM_RST_THR;
      wd_dur         <= `LSM_RST_WD_DUR;
      cluster_id     <= `LSM_RST_CID;
      wd_pattern     <= `LSM_RST_SW12;
      forced_closed  <= `LSM_RST_SW12;
      group_a_member <= `LSM_RST_SW12;
    end else begin
      if (thr_wr_ok && reg_addr_i == `LSM_ADDR_THR_1_4) begin
        thr_1_4 <= reg_wdata_i[`LSM_THR_MSB:0];
      end
      if (thr_wr_ok && reg_addr_i == `LSM_ADDR_THR_5_8) begin
        thr_5_8 <= reg_wdata_i[`LSM_THR_MSB:0];
      end
      if (thr_wr_ok && reg_addr_i == `LSM_ADDR_THR_9_12) begin
        thr_9_12 <= reg_wdata_i[`LSM_THR_MSB:0];
      end
      if (reg_wr_i && reg_addr_i == `LSM_ADDR_WDOG_CID) begin
        wd_dur <= reg_wdata_i[`LSM_WD_DUR_MSB:`LSM_WD_DUR_LSB];
        cluster_id <= reg_wdata_i[`LSM_CID_MSB:0];
      end
      if (reg_wr_i && reg_addr_i == `LSM_ADDR_WD_PATT) begin
        wd_pattern <= reg_wdata_i[`LSM_SW_MSB:0];
      end
      if (reg_wr_i && reg_addr_i == `LSM_ADDR_OVRD) begin
        forced_closed <= reg_wdata_i[`LSM_SW_MSB:0];
      end
      if (reg_wr_i && reg_addr_i == `LSM_ADDR_GRPA) begin
        group_a_member <= reg_wdata_i[`LSM_SW_MSB:0];
      end
    end
  end

  // ==========================================================
  // register reads, one cycle latency, unmapped reads give zero
  always @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `LSM_ADDR_THR_1_4:  reg_rdata_o <= {4'h0, thr_1_4};
          `LSM_ADDR_THR_5_8:  reg_rdata_o <= {4'h0, thr_5_8};
          `LSM_ADDR_THR_9_12: reg_rdata_o <= {4'h0, thr_9_12};
          `LSM_ADDR_WDOG_CID: reg_rdata_o <= {6'h00, wd_dur, cluster_id};
          `LSM_ADDR_WD_PATT:  reg_rdata_o <= {4'h0, wd_pattern};
          `LSM_ADDR_OVRD:     reg_rdata_o <= {4'h0, forced_closed};
          `LSM_ADDR_GRPA:     reg_rdata_o <= {4'h0, group_a_member};
          default:            reg_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================================
  // watchdog
  lsmcfg_wdog #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_wdog (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .dur_code_i (wd_dur),
    .kick_i     (valid_cmd_i),
    .timeout_o  (wd_timeout)
  );

  // set beats clear so a timeout in the clear cycle is not lost
  always @(posedge clk_i) begin
    if (srst_i) begin
      wd_flag_o <= 1'b0;
    end else if (wd_timeout) begin
      wd_flag_o <= 1'b1;
    end else if (wd_flag_clr_i) begin
      wd_flag_o <= 1'b0;
    end
  end

  assign fault_n_o = ~wd_flag_o;

  // ==========================================================
  // switch state: watchdog, then disable, then override, then pwm
  always @* begin
    if (wd_flag_o) begin
      next_switch_open = ~wd_pattern;
    end else if (!switching_enable_i) begin
      next_switch_open = 12'h000;
    end else begin
      next_switch_open = pwm_open_i & ~forced_closed;
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      switch_open_o <= 12'h000;
    end else begin
      switch_open_o <= next_switch_open;
    end
  end

  assign pwm_counter_clear_o = ~switching_enable_i;
  assign fault_detect_en_o   = switch_open_o;

  // ==========================================================
  // threshold codes to the fault comparators, switch 1 in the low bits
  assign short_threshold_select_o = {thr_9_12, thr_5_8, thr_1_4};

  // ==========================================================
  // addressing qualifiers
  assign cluster_accept_o = (cluster_id_rx_i == cluster_id);

  wire grp_code_a = (group_sel_code_i == `LSM_GRPA_CODE);
  assign group_a_duty_hit_o  = {12{group_a_duty_wr_i}}
                               & group_a_member;
  assign group_a_phase_hit_o = {12{group_phase_shift_wr_i & grp_code_a}}
                               & group_a_member;
  assign group_a_delay_hit_o = {12{group_dim_delay_wr_i & grp_code_a}}
                               & group_a_member;
endmodule // lsmcfg_regs

// ---- lsmcfg_regs_asserts.sv ----
`timescale 1ns/1ps
module lsmcfg_regs_asserts (
  // clock and reset
  input wire        clk_i,
  input wire        srst_i,
  // register writes
  input wire        reg_wr_i,
  input wire [7:0]  reg_addr_i,
  input wire [15:0] reg_wdata_i,
  // link and status
  input wire        valid_cmd_i,
  input wire [5:0]  cluster_id_rx_i,
  input wire        cluster_accept_o,
  input wire        wd_flag_o,
  input wire        fault_n_o,
  // switches and groups
  input wire        switching_enable_i,
  input wire [11:0] pwm_open_i,
  input wire [11:0] switch_open_o,
  input wire        pwm_counter_clear_o,
  input wire        group_a_duty_wr_i,
  input wire [11:0] group_a_duty_hit_o
);
  // ==========================================
  // shadow copies of the fields outputs use
  reg [11:0] patt, ovr, grp;
  reg [5:0]  clu_id;
  reg [3:0]  dur;
  always @(posedge clk_i) begin
    if (srst_i) begin
      {patt, ovr, grp, dur} <= 40'h0;
      clu_id <= 6'h01;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        8'h07: {dur, clu_id} <= reg_wdata_i[9:0];
        8'h08: patt <= reg_wdata_i[11:0];
        8'h09: ovr <= reg_wdata_i[11:0];
        8'h0A: grp <= reg_wdata_i[11:0];
        default: ;
      endcase
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_timeout;
    $rose(wd_flag_o);
  endsequence
  a_fault_on_flag: assert property (fault_n_o == !wd_flag_o)
    else $error("fault output does not follow watchdog flag");
  a_timeout_cause: assert property (s_timeout |->
    $past(dur, 2) != 4'h0 && !$past(valid_cmd_i, 2))
    else $error("watchdog flag rose without a silent period");
  a_pattern_on_flag: assert property (wd_flag_o |=>
    switch_open_o == ~$past(patt))
    else $error("fallback pattern not applied");
  a_closed_when_off: assert property (!switching_enable_i &&
    !wd_flag_o |=> switch_open_o == 12'h000)
    else $error("switch open while switching disabled");
  a_counter_held: assert property (
    pwm_counter_clear_o == !switching_enable_i)
    else $error("pwm counter clear wrong");
  a_override_closed: assert property (switching_enable_i &&
    !wd_flag_o |=> switch_open_o == ($past(pwm_open_i) & ~$past(ovr)))
    else $error("override or pwm request not honoured");
  a_cluster_match: assert property (
    cluster_accept_o == (cluster_id_rx_i == clu_id))
    else $error("cluster accept wrong");
  a_group_duty_hit: assert property (
    group_a_duty_hit_o == (grp & {12{group_a_duty_wr_i}}))
    else $error("group duty hit wrong");
endmodule // lsmcfg_regs_asserts
bind lsmcfg_regs lsmcfg_regs_asserts lsmcfg_regs_asserts_i (
  .clk_i               (clk_i),
  .srst_i              (srst_i),
  .reg_wr_i            (reg_wr_i),
  .reg_addr_i          (reg_addr_i),
  .reg_wdata_i         (reg_wdata_i),
  .valid_cmd_i         (valid_cmd_i),
  .cluster_id_rx_i     (cluster_id_rx_i),
  .cluster_accept_o    (cluster_accept_o),
  .wd_flag_o           (wd_flag_o),
  .fault_n_o           (fault_n_o),
  .switching_enable_i  (switching_enable_i),
  .pwm_open_i          (pwm_open_i),
  .switch_open_o       (switch_open_o),
  .pwm_counter_clear_o (pwm_counter_clear_o),
  .group_a_duty_wr_i   (group_a_duty_wr_i),
  .group_a_duty_hit_o  (group_a_duty_hit_o)
);

// ---- lsmcfg_host.sv ----
`timescale 1ns/1ps
module lsmcfg_host (
  // clock
  input  wire        clk_i,
  // register port
  output reg         reg_wr_o,
  output reg         reg_rd_o,
  output reg  [7:0]  reg_addr_o,
  output reg  [15:0] reg_wdata_o,
  input  wire [15:0] reg_rdata_i,
  input  wire        reg_rvalid_i,
  // command events
  output reg         valid_cmd_o
);
  initial begin
    {reg_wr_o, reg_rd_o, valid_cmd_o} = 3'b000;
    {reg_addr_o, reg_wdata_o} = 24'hFFFFFF;
  end
  // each write is a whole serial command, so it also kicks the watchdog
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge clk_i) #1;
      {reg_wr_o, valid_cmd_o, reg_addr_o, reg_wdata_o} = {2'b11, a, d};
      @(posedge clk_i) #1;
      // idle bus shows the inverse so stale values cannot pass
      {reg_wr_o, valid_cmd_o, reg_addr_o, reg_wdata_o} = {2'b00, ~a, ~d};
    end
  endtask
  task rd(input [7:0] a, output [15:0] d);
    begin
      @(posedge clk_i) #1;
      {reg_rd_o, reg_addr_o} = {1'b1, a};
      @(posedge clk_i) #1;
      {reg_rd_o, reg_addr_o} = {1'b0, ~a};
      d = reg_rvalid_i ? reg_rdata_i : 16'hXXXX;
    end
  endtask
endmodule // lsmcfg_host

// ---- lsmcfg_regs_tb.sv ----
`timescale 1ns/1ps
module lsmcfg_regs_tb;
  reg         clk_i, srst_i, clr, en, duty_wr, ph_wr, dl_wr;
  reg  [11:0] pwm;
  reg  [5:0]  clu_rx;
  reg  [3:0]  gcode;
  reg  [15:0] d;
  wire        wr, rd, vcmd, rvalid, accept, flag, fault_n, cnt_clr;
  wire [7:0]  addr;
  wire [15:0] wdata, rdata;
  wire [11:0] sw_open, det_en, hit_d, hit_p, hit_l;
  wire [35:0] thr;
  integer     err_total, total_checks, i, k;
  lsmcfg_host lsmcfg_host_i (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata),
    .reg_rvalid_i(rvalid), .valid_cmd_o(vcmd));
  lsmcfg_regs #(.TICK_CYCLES(2)) lsmcfg_regs_i (.clk_i(clk_i),
    .srst_i(srst_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .valid_cmd_i(vcmd), .cluster_id_rx_i(clu_rx), .cluster_accept_o(accept),
    .wd_flag_clr_i(clr), .wd_flag_o(flag), .fault_n_o(fault_n),
    .switching_enable_i(en), .pwm_open_i(pwm), .switch_open_o(sw_open),
    .pwm_counter_clear_o(cnt_clr), .fault_detect_en_o(det_en),
    .short_threshold_select_o(thr), .group_a_duty_wr_i(duty_wr),
    .group_phase_shift_wr_i(ph_wr), .group_dim_delay_wr_i(dl_wr),
    .group_sel_code_i(gcode), .group_a_duty_hit_o(hit_d),
    .group_a_phase_hit_o(hit_p), .group_a_delay_hit_o(hit_l));
  // ==========================================
  // helpers
  task step;
    @(posedge clk_i) #1;
  endtask
  task cmp(input [63:0] nm, input [35:0] e, input [35:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("ERROR %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task final_report;
    begin
      if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // ==========================================
  // scenarios
  task t_thr;
    begin
      en = 1'b0;
      lsmcfg_host_i.wr(8'h04, 16'h0688);
      lsmcfg_host_i.wr(8'h05, 16'h0FAC);
      lsmcfg_host_i.wr(8'h06, 16'h0977);
      for (i = 0; i < 4; i = i + 1)
        cmp("thr", i, thr[3*i+:3]);
      for (i = 4; i < 8; i = i + 1)
        cmp("thr", i, thr[3*i+:3]);
      for (i = 8; i < 12; i = i + 1)
        cmp("thr", 15 - i, thr[3*i+:3]);
      // enabled switching must leave thresholds untouched
      en = 1'b1;
      lsmcfg_host_i.wr(8'h05, 16'h0000);
      lsmcfg_host_i.rd(8'h05, d);
      cmp("locked", 16'h0FAC, d);
      lsmcfg_host_i.rd(8'h04, d);
      cmp("thr_1_4", 16'h0688, d);
    end
  endtask
  task t_cluster;
    begin
      clu_rx = 6'h2A;
      step;
      cmp("clu", 1'b0, accept);
      lsmcfg_host_i.wr(8'h07, 16'h002A);
      cmp("clu", 1'b1, accept);
      clu_rx = 6'h01;
      step;
      cmp("clu", 1'b0, accept);
    end
  endtask
  task t_ovrd;
    begin
      pwm = 12'hFFF;
      lsmcfg_host_i.wr(8'h09, 16'h00A5);
      step;
      cmp("sw_open", 12'hF5A, sw_open);
      cmp("detect", 12'hF5A, det_en);
      en = 1'b0;
      step;
      cmp("sw_open", 12'h000, sw_open);
      cmp("cnt_clr", 1'b1, cnt_clr);
      en = 1'b1;
      lsmcfg_host_i.wr(8'h09, 16'h0000);
      step;
      cmp("sw_open", 12'hFFF, sw_open);
      pwm = 12'h000;
    end
  endtask
  task t_group;
    begin
      lsmcfg_host_i.wr(8'h0A, 16'h0813);
      duty_wr = 1'b1;
      step;
      cmp("duty_hit", 12'h813, hit_d);
      {duty_wr, ph_wr, dl_wr} = 3'b011;
      for (k = 1; k < 3; k = k + 1) begin
        gcode = k[3:0];
        step;
        cmp("ph_hit", (k == 1) ? 12'h813 : 12'h000, hit_p);
        cmp("dl_hit", (k == 1) ? 12'h813 : 12'h000, hit_l);
      end
      {ph_wr, dl_wr} = 2'b00;
      lsmcfg_host_i.wr(8'h0A, 16'h0012);
      duty_wr = 1'b1;
      step;
      cmp("duty_hit", 12'h012, hit_d);
      duty_wr = 1'b0;
    end
  endtask
  task t_wdog;
    begin
      lsmcfg_host_i.wr(8'h08, 16'h03C5);
      for (k = 0; k < 2; k = k + 1) begin
        lsmcfg_host_i.wr(8'h07, k ? 16'h0081 : 16'h0041);
        repeat (k ? 980 : 380) step;
        cmp("flag", 1'b0, flag);
        for (i = 0; i < 40 && flag !== 1'b1; i = i + 1) step;
        cmp("flag", 1'b1, flag);
        cmp("fault_n", 1'b0, fault_n);
        step;
        cmp("sw_open", 12'hC3A, sw_open);
        lsmcfg_host_i.wr(8'h08, 16'h03C5);
        clr = 1'b1;
        step;
        clr = 1'b0;
        step;
        cmp("fault_n", 1'b1, fault_n);
      end
      lsmcfg_host_i.wr(8'h07, 16'h0001);
      repeat (500) step;
      cmp("flag", 1'b0, flag);
    end
  endtask
  // ==========================================
  // run
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    err_total = err_total + 1;
    final_report;
  end
  initial begin
    {err_total, total_checks} = 64'h0;
    {srst_i, clr, en, duty_wr, ph_wr, dl_wr} = 6'b100000;
    {pwm, clu_rx, gcode} = 22'h000040;
    repeat (20) @(posedge clk_i);
    #1 srst_i = 1'b0;
    for (i = 4; i < 12; i = i + 1) begin
      lsmcfg_host_i.rd(i[7:0], d);
      cmp("reset", (i == 7) ? 16'h0001 : 16'h0000, d);
    end
    t_thr;
    t_cluster;
    t_ovrd;
    t_group;
    t_wdog;
    final_report;
  end
endmodule // lsmcfg_regs_tb
